// >>> porsq_top.sv
// power-on reset sequencer: steps memory reset, config load, inputs, luts,
// remaining macrocells, reset-done and finally the output pins
// assumes supply_ok_in comes from an analog detector, nvm answers one cycle after a read
`timescale 1ns/10ps
`default_nettype none
`include "porsq_consts.svh"

// Overview of operation
// - start once supply detector reports threshold crossed
// - reset config memory first
// - load memory contents into config registers
// - hold input buffers in reset, then enable
// - reset luts, then activate them
// - then initialise delays, oscillator, flops, pipe
// - reset-done rises only after all init
// - output pins released last, after reset-done
// - pins high impedance throughout sequence
// - macrocell outputs low before memory reset
// - macrocell outputs undefined until config ready
// - input buffer and lut outputs low early
// - only edge-detector delay cell active early
// - released pins follow loaded direction config
module porsq_top
	import porsq_pkg::*;
#(
	parameter int NUM_PINS = 8,
	parameter int NUM_LUTS = 4,
	parameter int CFG_WORDS = 4,
	parameter int CFG_W = 8,
	parameter int STEP_CYC = `PORSQ_STEP_CYC
)(
	// clock and reset
	input wire logic clk_in,
	input wire logic sys_rst_in,
	// supply detector
	input wire logic supply_ok_in,
	// configuration memory
	output logic nvm_rst_out,
	output logic nvm_rd_out,
	output logic [$clog2(CFG_WORDS)-1:0] nvm_addr_out,
	input wire logic [CFG_W-1:0] nvm_data_in,
	output logic [CFG_WORDS*CFG_W-1:0] cfg_out,
	// macrocell controls
	output logic macro_force_low_out,
	output logic macro_valid_out,
	output logic in_buf_rst_out,
	output logic in_buf_en_out,
	output logic lut_rst_out,
	output logic lut_en_out,
	output logic edge_det_en_out,
	output logic macro_init_out,
	output logic macro_run_out,
	output logic por_done_out,
	// input pins and lut results
	input wire logic [NUM_PINS-1:0] pin_in,
	output logic [NUM_PINS-1:0] in_buf_out,
	input wire logic [NUM_LUTS-1:0] lut_res_in,
	output logic [NUM_LUTS-1:0] lut_out,
	// output pins
	input wire logic [NUM_PINS-1:0] pin_src_in,
	output logic [NUM_PINS-1:0] pin_out,
	output logic [NUM_PINS-1:0] pin_oe_n_out
);

	localparam int IW = $clog2(CFG_WORDS);

	typedef struct packed {
		porsq_state_t state;
		logic pend;
		logic [IW-1:0] idx;
		logic [CFG_WORDS-1:0][CFG_W-1:0] cfg;
		logic [NUM_PINS-1:0] in_buf;
		logic [NUM_LUTS-1:0] lut;
		logic [NUM_PINS-1:0] pin;
		logic [NUM_PINS-1:0] oe_n;
	} porsq_top_st_t;

	porsq_top_st_t st_r;
	porsq_top_st_t st_nxt;
	logic supply_ok;
	logic [NUM_PINS-1:0] pin_sync;
	logic tmr_clr;
	logic tmr_exp;
	logic [NUM_PINS-1:0] dir;

	if (CFG_WORDS < 2 || CFG_W < NUM_PINS || CFG_W < 1 || NUM_LUTS < 1)
	begin : g_chk
		$error("porsq_top: CFG_WORDS >= 2 and CFG_W >= NUM_PINS needed");
	end

	function automatic logic at_or_after(input porsq_state_t s, input porsq_state_t ref_s);
		at_or_after = (s >= ref_s);
	endfunction

	porsq_sync #(
		.W(1)
	) u_sup_sync (
		.clk_in(clk_in),
		.sys_rst_in(sys_rst_in),
		.async_in(supply_ok_in),
		.sync_out(supply_ok)
	);

	porsq_sync #(
		.W(NUM_PINS)
	) u_pin_sync (
		.clk_in(clk_in),
		.sys_rst_in(sys_rst_in),
		.async_in(pin_in),
		.sync_out(pin_sync)
	);

	porsq_timer #(
		.LEN(STEP_CYC)
	) u_timer (
		.clk_in(clk_in),
		.sys_rst_in(sys_rst_in),
		.clr_in(tmr_clr),
		.expired_out(tmr_exp)
	);

	assign dir = st_r.cfg[`PORSQ_DIR_WORD][NUM_PINS-1:0];

	always_comb
	begin
		st_nxt = st_r;
		case (st_r.state)
			PORSQ_OFF:
			begin
				if (supply_ok)
					st_nxt.state = PORSQ_NVM_RST;
			end
			PORSQ_NVM_RST:
			begin
				if (tmr_exp)
				begin
					st_nxt.state = PORSQ_LOAD;
					st_nxt.idx = '0;
					st_nxt.pend = 1'b0;
				end
			end
			PORSQ_LOAD:
			begin
				// each word takes a read cycle and a capture cycle
				if (st_r.pend)
				begin
					st_nxt.cfg[st_r.idx] = nvm_data_in;
					st_nxt.pend = 1'b0;
					if (st_r.idx == IW'(CFG_WORDS - 1))
						st_nxt.state = PORSQ_IN_RST;
					else
						st_nxt.idx = st_r.idx + 1'b1;
				end
				else
					st_nxt.pend = 1'b1;
			end
			PORSQ_IN_RST:
			begin
				if (tmr_exp)
					st_nxt.state = PORSQ_IN_EN;
			end
			PORSQ_IN_EN:
			begin
				if (tmr_exp)
					st_nxt.state = PORSQ_LUT_RST;
			end
			PORSQ_LUT_RST:
			begin
				if (tmr_exp)
					st_nxt.state = PORSQ_LUT_EN;
			end
			PORSQ_LUT_EN:
			begin
				if (tmr_exp)
					st_nxt.state = PORSQ_MACRO;
			end
			PORSQ_MACRO:
			begin
				if (tmr_exp)
					st_nxt.state = PORSQ_DONE;
			end
			PORSQ_DONE:
			begin
				if (tmr_exp)
					st_nxt.state = PORSQ_RUN;
			end
			PORSQ_RUN:
			begin
				st_nxt.state = PORSQ_RUN;
			end
			default:
			begin
				st_nxt.state = PORSQ_OFF;
			end
		endcase
		// supply loss overrides every step
		if (!supply_ok)
		begin
			st_nxt.state = PORSQ_OFF;
			st_nxt.pend = 1'b0;
		end
		// gated on the next state so data lines up with the strobes
		if (at_or_after(st_nxt.state, PORSQ_IN_EN))
			st_nxt.in_buf = pin_sync;
		else
			st_nxt.in_buf = '0;
		if (at_or_after(st_nxt.state, PORSQ_LUT_EN))
			st_nxt.lut = lut_res_in;
		else
			st_nxt.lut = '0;
		st_nxt.pin = pin_src_in;
		if (st_nxt.state == PORSQ_RUN)
			st_nxt.oe_n = ~dir;
		else
			st_nxt.oe_n = '1;
	end

	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			st_r <= '0;
			st_r.oe_n <= '1;
		end
		else
			st_r <= st_nxt;
	end

	// timer restarts on every step change
	assign tmr_clr = (st_nxt.state != st_r.state) || (st_r.state == PORSQ_OFF);

	assign nvm_rst_out = (st_r.state == PORSQ_NVM_RST);
	assign nvm_rd_out = (st_r.state == PORSQ_LOAD) && !st_r.pend;
	assign nvm_addr_out = st_r.idx;
	assign cfg_out = st_r.cfg;
	assign macro_force_low_out = !at_or_after(st_r.state, PORSQ_LOAD);
	// config is ready only after the last word is captured
	assign macro_valid_out = at_or_after(st_r.state, PORSQ_IN_RST);
	assign in_buf_rst_out = (st_r.state == PORSQ_IN_RST);
	assign in_buf_en_out = at_or_after(st_r.state, PORSQ_IN_EN);
	assign lut_rst_out = (st_r.state == PORSQ_LUT_RST);
	assign lut_en_out = at_or_after(st_r.state, PORSQ_LUT_EN);
	assign edge_det_en_out = at_or_after(st_r.state, PORSQ_IN_RST)
		&& st_r.cfg[`PORSQ_EDGE_WORD][`PORSQ_EDGE_BIT];
	assign macro_init_out = (st_r.state == PORSQ_MACRO);
	assign macro_run_out = at_or_after(st_r.state, PORSQ_DONE);
	assign por_done_out = at_or_after(st_r.state, PORSQ_DONE);
	assign in_buf_out = st_r.in_buf;
	assign lut_out = st_r.lut;
	assign pin_out = st_r.pin;
	assign pin_oe_n_out = st_r.oe_n;

	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (sys_rst_in);

	property p_start;
		(st_r.state == PORSQ_OFF) && supply_ok |=> nvm_rst_out;
	endproperty
	a_start: assert property (p_start) else $error("sequence did not start");

	property p_rst_first;
		$rose(nvm_rd_out) && (st_r.idx == '0) |-> $past(nvm_rst_out, 2) || $past(nvm_rst_out);
	endproperty
	a_rst_first: assert property (p_rst_first) else $error("read before memory reset");

	property p_load;
		$rose(macro_valid_out) |-> $past(st_r.state) == PORSQ_LOAD && $past(st_r.pend);
	endproperty
	a_load: assert property (p_load) else $error("config ready without load");

	property p_in_order;
		$rose(in_buf_en_out) |-> $past(in_buf_rst_out) && $past(in_buf_rst_out, 2);
	endproperty
	a_in_order: assert property (p_in_order) else $error("inputs enabled without reset");

	property p_lut_order;
		$rose(lut_en_out) |-> in_buf_en_out && $past(lut_rst_out);
	endproperty
	a_lut_order: assert property (p_lut_order) else $error("luts active out of order");

	property p_done;
		$rose(por_done_out) |-> $past(macro_init_out) && lut_en_out;
	endproperty
	a_done: assert property (p_done) else $error("reset-done too early");

	property p_pins;
		(pin_oe_n_out != '1) |-> por_done_out && $past(por_done_out);
	endproperty
	a_pins: assert property (p_pins) else $error("pin driven before reset-done");

	property p_force_low;
		!in_buf_en_out |-> (in_buf_out == '0) && (lut_out == '0);
	endproperty
	a_force_low: assert property (p_force_low) else $error("early output not low");

	property p_edge;
		edge_det_en_out |-> macro_valid_out && !macro_force_low_out;
	endproperty
	a_edge: assert property (p_edge) else $error("edge detector active too early");

	property p_loss;
		!supply_ok |=> !por_done_out && (pin_oe_n_out == '1) && macro_force_low_out;
	endproperty
	a_loss: assert property (p_loss) else $error("supply loss not handled");

endmodule
`default_nettype wire

// >>> porsq_consts.svh
// constants of the power-on reset sequencer: timing counts, config layout, reset values
// assumes a 50 MHz system clock; included by bare name
`ifndef PORSQ_CONSTS_SVH
`define PORSQ_CONSTS_SVH

// clock period in ns
`define PORSQ_CLK_NS 20
// nominal supply threshold that starts the sequence, in mV (analog, detector side)
`define PORSQ_PWR_ON_MV 1600
// least dwell time of each timed step, in ns
`define PORSQ_STEP_NS 200
// dwell time in clock cycles, rounded up
`define PORSQ_STEP_CYC ((`PORSQ_STEP_NS + `PORSQ_CLK_NS - 1) / `PORSQ_CLK_NS)
// config word holding the pin direction bits (1 = output)
`define PORSQ_DIR_WORD 0
// config word and bit that make the programmable delay cell an edge detector
`define PORSQ_EDGE_WORD 1
`define PORSQ_EDGE_BIT 0
// reset value of every synchroniser stage
`define PORSQ_SYNC_RST 1'b0

`endif

// >>> porsq_pkg.sv
// types shared by the power-on reset sequencer modules
// assumes nothing of its surroundings
package porsq_pkg;

	typedef enum logic [3:0] {
		PORSQ_OFF = 4'h0,
		PORSQ_NVM_RST = 4'h1,
		PORSQ_LOAD = 4'h2,
		PORSQ_IN_RST = 4'h3,
		PORSQ_IN_EN = 4'h4,
		PORSQ_LUT_RST = 4'h5,
		PORSQ_LUT_EN = 4'h6,
		PORSQ_MACRO = 4'h7,
		PORSQ_DONE = 4'h8,
		PORSQ_RUN = 4'h9
	} porsq_state_t;

endpackage

// >>> porsq_sync.sv
// three-stage synchroniser; output changes once stages two and three agree
// assumes inputs asynchronous to clk_in
`timescale 1ns/10ps
`default_nettype none
`include "porsq_consts.svh"

module porsq_sync
	import porsq_pkg::*;
#(
	parameter int W = 1
)(
	// clock and reset
	input wire logic clk_in,
	input wire logic sys_rst_in,
	// data
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] q;
	} porsq_sync_st_t;

	porsq_sync_st_t st_r;
	porsq_sync_st_t st_nxt;

	if (W < 1)
	begin : g_chk
		$error("porsq_sync: W must be at least 1");
	end

	always_comb
	begin
		st_nxt = st_r;
		st_nxt.s1 = async_in;
		st_nxt.s2 = st_r.s1;
		st_nxt.s3 = st_r.s2;
		// hold on disagreement filters a single-cycle glitch
		st_nxt.q = (st_r.s2 & st_r.s3) | (st_r.q & (st_r.s2 | st_r.s3));
	end

	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
			st_r <= {4 * W{`PORSQ_SYNC_RST}};
		else
			st_r <= st_nxt;
	end

	assign sync_out = st_r.q;

endmodule
`default_nettype wire

// >>> porsq_timer.sv
// step dwell timer; expired_out is a level until cleared
// assumes clr_in is driven by logic on clk_in
`timescale 1ns/10ps
`default_nettype none

module porsq_timer
	import porsq_pkg::*;
#(
	parameter int LEN = 10
)(
	// clock and reset
	input wire logic clk_in,
	input wire logic sys_rst_in,
	// control
	input wire logic clr_in,
	output logic expired_out
);

	localparam int CW = $clog2(LEN);

	typedef struct packed {
		logic [CW-1:0] cnt;
	} porsq_timer_st_t;

	porsq_timer_st_t st_r;
	porsq_timer_st_t st_nxt;

	if (LEN < 2)
	begin : g_chk
		$error("porsq_timer: LEN must be at least 2");
	end

	assign expired_out = (st_r.cnt == CW'(LEN - 1));

	always_comb
	begin
		st_nxt = st_r;
		if (clr_in)
			st_nxt.cnt = '0;
		else if (!expired_out)
			st_nxt.cnt = st_r.cnt + 1'b1;
	end

	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

endmodule
`default_nettype wire

// >>> power_on_reset_sequencer_bench.sv
// self-checking bench of the power-on reset sequencer top
// assumes porsq_top as declared; bench plays supply detector, nvm and pins
`timescale 1ns/10ps
`default_nettype none

module power_on_reset_sequencer_bench;
	localparam int S = 3;
	logic clk_in = 1'b0;
	logic sys_rst_in = 1'b1;
	logic supply_ok_in = 1'b0;
	logic nvm_rst_out, nvm_rd_out, macro_force_low_out, macro_valid_out;
	logic in_buf_rst_out, in_buf_en_out, lut_rst_out, lut_en_out, edge_det_en_out;
	logic macro_init_out, macro_run_out, por_done_out;
	logic [1:0] nvm_addr_out, addr_q;
	logic [7:0] nvm_data_in = 8'h00;
	logic [31:0] cfg_out;
	logic [7:0] pin_in = 8'h96;
	logic [7:0] in_buf_out, pin_out, pin_oe_n_out;
	logic [7:0] pin_src_in = 8'h6B;
	logic [3:0] lut_res_in = 4'hD;
	logic [3:0] lut_out;
	logic [7:0] mem [4];
	logic [9:0] s;
	logic rd_q, le_q, ie_q, pd_q, bad_z, bad_pin, bad_fl, bad_ed, bad_rd;
	int t [10];
	int cyc, rd_n, rst_len, fails, checks_done, all_cyc, n;

	porsq_top #(.STEP_CYC(S)) uut (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
		.supply_ok_in(supply_ok_in), .nvm_rst_out(nvm_rst_out), .nvm_rd_out(nvm_rd_out),
		.nvm_addr_out(nvm_addr_out), .nvm_data_in(nvm_data_in), .cfg_out(cfg_out),
		.macro_force_low_out(macro_force_low_out), .macro_valid_out(macro_valid_out),
		.in_buf_rst_out(in_buf_rst_out), .in_buf_en_out(in_buf_en_out),
		.lut_rst_out(lut_rst_out), .lut_en_out(lut_en_out),
		.edge_det_en_out(edge_det_en_out), .macro_init_out(macro_init_out),
		.macro_run_out(macro_run_out), .por_done_out(por_done_out), .pin_in(pin_in),
		.in_buf_out(in_buf_out), .lut_res_in(lut_res_in), .lut_out(lut_out),
		.pin_src_in(pin_src_in), .pin_out(pin_out), .pin_oe_n_out(pin_oe_n_out));

	initial
	begin
		forever #10 clk_in = ~clk_in;
	end

	// nvm answers one cycle after the strobe, garbage otherwise
	always @(posedge clk_in)
	begin
		rd_q <= nvm_rd_out;
		addr_q <= nvm_addr_out;
	end
	always @(negedge clk_in)
		nvm_data_in <= rd_q ? mem[addr_q] : ~nvm_data_in;

	// first-rise times and standing checks, sampled mid-cycle
	always @(negedge clk_in)
	begin
		s = {pin_oe_n_out !== 8'hFF, por_done_out, macro_init_out, lut_en_out, lut_rst_out,
			in_buf_en_out, in_buf_rst_out, macro_valid_out, nvm_rd_out, nvm_rst_out};
		cyc++;
		if (!sys_rst_in)
		begin
			for (int i = 0; i < 10; i++)
				if (t[i] < 0 && s[i] === 1'b1)
					t[i] = cyc;
			if (nvm_rst_out === 1'b1)
				rst_len++;
			if (nvm_rd_out === 1'b1)
			begin
				if (nvm_addr_out !== rd_n[1:0] || t[0] < 0)
					bad_rd = 1'b1;
				rd_n++;
			end
			// outputs are registers, so allow one cycle after enable drops
			if ((!in_buf_en_out && !ie_q && in_buf_out !== 8'h00) ||
				(!lut_en_out && !le_q && lut_out !== 4'h0))
				bad_z = 1'b1;
			if (por_done_out !== 1'b1 && !pd_q && pin_oe_n_out !== 8'hFF)
				bad_pin = 1'b1;
			if ((t[0] < 0 && macro_force_low_out !== 1'b1) ||
				(macro_valid_out === 1'b1 && macro_force_low_out !== 1'b0))
				bad_fl = 1'b1;
			if (edge_det_en_out !== (macro_valid_out & mem[1][0]))
				bad_ed = 1'b1;
		end
		ie_q = in_buf_en_out;
		le_q = lut_en_out;
		pd_q = por_done_out;
	end

	task automatic test_done();
		if (fails == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// long enough for three short sequences with margin
	always @(posedge clk_in)
	begin
		all_cyc++;
		if (all_cyc == 5000)
		begin
			fails++;
			$display("MISMATCH %0t timeout", $time);
			test_done();
		end
	end

	task automatic chk(input logic ok, input string m);
		checks_done++;
		if (ok !== 1'b1)
		begin
			fails++;
			$display("MISMATCH %0t %s", $time, m);
		end
	endtask

	task automatic clear_mon();
		for (int i = 0; i < 10; i++)
			t[i] = -1;
		{rd_n, rst_len} = 0;
		{bad_z, bad_pin, bad_fl, bad_ed, bad_rd} = 5'h00;
	endtask

	task automatic t_reset();
		chk(pin_oe_n_out === 8'hFF && macro_force_low_out === 1'b1, "reset pins");
		chk(por_done_out === 1'b0 && nvm_rst_out === 1'b0, "reset outputs");
		chk(cfg_out === 32'h0 && in_buf_out === 8'h00 && lut_out === 4'h0, "reset data");
	endtask

	task automatic t_power_up(input logic [7:0] dir, input logic [7:0] ed);
		int c0;
		mem = '{dir, ed, 8'h3C, 8'hC3};
		clear_mon();
		supply_ok_in = 1'b1;
		// rise times are absolute cycle counts, so latency is taken from here
		c0 = cyc;
		for (n = 0; n < 300 && t[9] < 0; n++)
			@(negedge clk_in);
		repeat (2) @(negedge clk_in);
		chk(t[0] - c0 > 0 && t[0] - c0 < 8, "start latency");
		chk(rst_len == S && t[1] == t[0] + S, "nvm reset dwell");
		chk(rd_n == 4 && !bad_rd, "read order");
		chk(t[2] == t[1] + 8 && t[3] == t[2], "load length");
		chk(cfg_out === {8'hC3, 8'h3C, ed, dir}, "config");
		for (int i = 3; i < 9; i++)
			chk(t[i + 1] == t[i] + S, "step order");
		chk(!bad_z && !bad_pin, "early outputs");
		chk(!bad_fl, "force low");
		chk(!bad_ed, "edge detector");
		chk(pin_oe_n_out === ~dir && pin_out === pin_src_in, "pins");
		chk(in_buf_out === pin_in && lut_out === lut_res_in, "live paths");
		chk(macro_run_out === 1'b1, "run");
	endtask

	task automatic t_drop();
		supply_ok_in = 1'b0;
		for (n = 0; n < 12 && (por_done_out !== 1'b0 || nvm_rd_out !== 1'b0 ||
			nvm_rst_out !== 1'b0 || macro_force_low_out !== 1'b1); n++)
			@(negedge clk_in);
		repeat (2) @(negedge clk_in);
		chk(n < 12 && pin_oe_n_out === 8'hFF && macro_valid_out === 1'b0, "drop");
		chk(in_buf_out === 8'h00 && lut_out === 4'h0 && edge_det_en_out === 1'b0, "drop");
	endtask

	// supply lost in the middle of the config load
	task automatic t_abort();
		clear_mon();
		supply_ok_in = 1'b1;
		for (n = 0; n < 100 && rd_n < 2; n++)
			@(negedge clk_in);
		t_drop();
		chk(t[2] < 0 && !bad_pin, "abort");
		repeat (4) @(negedge clk_in);
	endtask

	initial
	begin
		clear_mon();
		mem = '{8'h00, 8'h00, 8'h00, 8'h00};
		repeat (12) @(negedge clk_in);
		t_reset();
		sys_rst_in = 1'b0;
		t_power_up(8'hA5, 8'h01);
		t_drop();
		t_abort();
		t_power_up(8'h5A, 8'hFE);
		t_drop();
		test_done();
	end
endmodule

`default_nettype wire
